// ==== inc/pdmm_consts.vh ====
// constants for the program and data memory map block
`ifndef PDMM_CONSTS_VH
`define PDMM_CONSTS_VH
`define PDMM_ROM_AW 12
`define PDMM_RAM_AW 8
`define PDMM_ROM_WORDS_SMALL 12'h0800
`define PDMM_ROM_WORDS_LARGE 12'h0C00
`define PDMM_RAM_DEPTH 192
`define PDMM_ROM_DEPTH 3072
`define PDMM_LARGE_FOLD_BASE 8'h80
`define PDMM_RAM_PHYS_AW 8
`define PDMM_RAM_TOP_BIT 7
`define PDMM_LARGE_ALIAS_BIT 6
`define PDMM_LARGE_UPPER_BASE 8'h40
`define PDMM_RAM_ZERO 4'h0
`define PDMM_ROM_ZERO 8'h00
`endif

// ==== src/pdmm_program_data_memory_map.v ====
// program memory and data memory address map with per-variant aliasing
// How it works
// R1: program memory is byte-wide, 2048 words (0x000-0x7FF) small, 3072 large.
// R2: table look-up reads any populated program address into the accumulator.
// R3: the nibble-to-byte output instruction is unsupported and gets no path.
// R4: data memory is nibble-wide, 128 words small, 192 words large.
// R5: the small variant treats the top data address bit as zero.
// R6: the large variant folds 0xC0-0xFF onto the cells at 0x80-0xBF.
// R7: software should use only the documented data addresses, not aliases.
`timescale 1ns/1ps
`default_nettype none
`include "pdmm_consts.vh"
module pdmm_program_data_memory_map #(
    parameter LARGE_VARIANT = 0
) (
    input wire sys_clk,
    input wire srst,
    input wire clk_en,
    // instruction fetch
    input wire fetch_req,
    input wire [11:0] fetch_addr,
    // table look-up (high or low load via table pointer register)
    input wire tbl_req,
    input wire [11:0] table_pointer_register,
    // program image load port
    input wire rom_wr,
    input wire [11:0] rom_wr_addr,
    input wire [7:0] rom_wr_data,
    // data access via data pointer pair
    input wire ram_rd,
    input wire ram_wr,
    input wire [7:0] data_pointer_pair,
    input wire [3:0] ram_wr_data,
    // nibble-to-byte output request, always refused
    input wire nibble_to_byte_output_instruction,
    output reg [7:0] fetch_data,
    output reg fetch_valid,
    output reg fetch_range_err,
    output reg [7:0] tbl_data,
    output reg tbl_valid,
    output reg tbl_range_err,
    output reg [3:0] ram_rd_data,
    output reg ram_rd_valid,
    output reg unsupported_instr
);
    // variant choice is fixed at build time
    localparam IS_LARGE = (LARGE_VARIANT != 0);

    // request qualifiers for the program memory paths
    wire [11:0] rom_limit;
    wire fetch_ok;
    wire tbl_ok;
    wire wr_ok;
    wire fetch_take;
    wire fetch_refuse;
    wire tbl_take;
    wire tbl_refuse;
    wire rom_wr_take;

    // fields of the data address
    wire addr_top;
    wire [5:0] addr_low6;
    wire [6:0] addr_low7;
    reg [7:0] next_phys;

    // next values of the registered flags
    reg next_fetch_valid;
    reg next_fetch_range_err;
    reg next_tbl_valid;
    reg next_tbl_range_err;
    reg next_ram_rd_valid;
    reg next_unsupported_instr;

    // storage sized for the large variant; the small one uses the low part
    reg [7:0] rom [0:`PDMM_ROM_DEPTH-1];
    reg [3:0] ram [0:`PDMM_RAM_DEPTH-1];

    // the limit is one past the last populated word, so one compare
    // refuses the whole unpopulated range
    assign rom_limit = IS_LARGE ? `PDMM_ROM_WORDS_LARGE
                                : `PDMM_ROM_WORDS_SMALL; // [R1]
    assign fetch_ok = (fetch_addr < rom_limit); // [R1]
    assign tbl_ok = (table_pointer_register < rom_limit); // [R2]
    assign wr_ok = (rom_wr_addr < rom_limit); // [R1]

    assign fetch_take = fetch_req & fetch_ok; // [R1]
    assign fetch_refuse = fetch_req & ~fetch_ok; // [R1]
    assign tbl_take = tbl_req & tbl_ok; // [R2]
    assign tbl_refuse = tbl_req & ~tbl_ok; // [R2]
    // loads past the limit are dropped, so no image lands in a hole
    assign rom_wr_take = rom_wr & wr_ok; // [R1]

    assign addr_top = data_pointer_pair[`PDMM_RAM_TOP_BIT];
    assign addr_low6 = data_pointer_pair[`PDMM_LARGE_ALIAS_BIT-1:0];
    assign addr_low7 = data_pointer_pair[`PDMM_RAM_TOP_BIT-1:0];

    // physical cell index: small keeps cells 0-127, large packs 192 cells
    always @* begin
        next_phys = {1'b0, addr_low7};
        if (!IS_LARGE) begin
            // top bit ignored: 0x80-0xFF share cells with 0x00-0x7F
            next_phys = {1'b0, addr_low7}; // [R5]
        end else if (addr_top) begin
            // bit 6 dropped so that 0x80-0xBF and 0xC0-0xFF meet
            next_phys = `PDMM_LARGE_FOLD_BASE | {2'b00, addr_low6}; // [R6]
        end else begin
            next_phys = {1'b0, addr_low7}; // [R4]
        end
    end

    // fetch flags: exactly one of them answers each request
    always @* begin
        next_fetch_valid = fetch_take; // [R1]
        next_fetch_range_err = fetch_refuse; // [R1]
    end

    // table look-up flags
    always @* begin
        next_tbl_valid = tbl_take; // [R2]
        next_tbl_range_err = tbl_refuse; // [R2]
    end

    // data read answers every request; all data addresses are mapped
    always @* begin
        next_ram_rd_valid = ram_rd; // [R4]
    end

    // no byte-output path exists; the request is only flagged
    always @* begin
        next_unsupported_instr = nibble_to_byte_output_instruction; // [R3]
    end

    // program image load; not reset, contents survive srst
    always @(posedge sys_clk) begin
        if (clk_en) begin
            if (rom_wr_take) begin
                rom[rom_wr_addr] <= rom_wr_data; // [R1]
            end
        end
    end

    // data write through the folded index
    always @(posedge sys_clk) begin
        if (clk_en) begin
            if (ram_wr) begin
                ram[next_phys] <= ram_wr_data; // [R4]
            end
        end
    end

    // instruction fetch path
    always @(posedge sys_clk) begin
        if (srst) begin
            fetch_data <= `PDMM_ROM_ZERO;
            fetch_valid <= 1'b0;
            fetch_range_err <= 1'b0;
        end else if (clk_en) begin
            fetch_valid <= next_fetch_valid; // [R1]
            fetch_range_err <= next_fetch_range_err; // [R1]
            // data holds on a refused fetch, the last good word stays
            if (fetch_take) begin
                fetch_data <= rom[fetch_addr]; // [R1]
            end
        end
    end

    // table look-up path: the word is bound for the accumulator
    always @(posedge sys_clk) begin
        if (srst) begin
            tbl_data <= `PDMM_ROM_ZERO;
            tbl_valid <= 1'b0;
            tbl_range_err <= 1'b0;
        end else if (clk_en) begin
            tbl_valid <= next_tbl_valid; // [R2]
            tbl_range_err <= next_tbl_range_err; // [R2]
            if (tbl_take) begin
                tbl_data <= rom[table_pointer_register]; // [R2]
            end
        end
    end

    // data read path
    always @(posedge sys_clk) begin
        if (srst) begin
            ram_rd_data <= `PDMM_RAM_ZERO;
            ram_rd_valid <= 1'b0;
        end else if (clk_en) begin
            ram_rd_valid <= next_ram_rd_valid; // [R4]
            if (ram_rd) begin
                // same-cycle write is not forwarded: the old value is read
                ram_rd_data <= ram[next_phys]; // [R4]
            end
        end
    end

    // unsupported instruction flag
    always @(posedge sys_clk) begin
        if (srst) begin
            unsupported_instr <= 1'b0;
        end else if (clk_en) begin
            unsupported_instr <= next_unsupported_instr; // [R3]
        end
    end
endmodule // pdmm_program_data_memory_map
`default_nettype wire

// ==== verification/pdmm_cpu_model.sv ====
// cpu core side: one request per call
`timescale 1ns/1ps
`default_nettype none
module pdmm_cpu_model (input wire logic sys_clk,
    output logic srst = 1, clk_en = 1, fetch_req = 0, tbl_req = 0, rom_wr = 0,
    ram_rd = 0, ram_wr = 0, nibble_to_byte_output_instruction = 0,
    output logic [11:0] fetch_addr = 0, table_pointer_register = 0,
    rom_wr_addr = 0, output logic [7:0] rom_wr_data = 0, data_pointer_pair = 0,
    output logic [3:0] ram_wr_data = 0);
    // strobes drop after one edge; aliases only when a scenario asks
    task op(input [5:0] k, input [11:0] a, input [7:0] d);
        @(posedge sys_clk);
        {nibble_to_byte_output_instruction, ram_wr, ram_rd, rom_wr, tbl_req,
            fetch_req} <= k;
        {fetch_addr, table_pointer_register, rom_wr_addr} <= {3{a}};
        {data_pointer_pair, rom_wr_data, ram_wr_data} <= {a[7:0], d, d[3:0]};
        @(posedge sys_clk);
        {nibble_to_byte_output_instruction, ram_wr, ram_rd, rom_wr, tbl_req,
            fetch_req} <= 6'h00;
    endtask
    task release_reset;
        srst <= 1'b0;
    endtask
    task hold(input logic en);
        @(posedge sys_clk);
        clk_en <= en;
    endtask
endmodule // pdmm_cpu_model
`default_nettype wire

// ==== verification/pdmm_map_props.sv ====
// port checks for the memory map
`timescale 1ns/1ps
`default_nettype none
module pdmm_map_props #(parameter LARGE_VARIANT = 0) (input wire sys_clk,
    srst, clk_en, tbl_req, tbl_valid, tbl_range_err, fetch_req, fetch_valid,
    ram_rd, ram_rd_valid, unsupported_instr, nibble_to_byte_output_instruction,
    input wire [11:0] table_pointer_register, fetch_addr);
    wire [12:0] lim = LARGE_VARIANT ? 13'h0C00 : 13'h0800;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    chk_fetch_range: assert property (clk_en && fetch_req |=>
        fetch_valid == ($past(fetch_addr) < lim)) else $error("fetch");
    chk_tbl_range: assert property (clk_en && tbl_req |=>
        tbl_valid == ($past(table_pointer_register) < lim)) else $error("tbl");
    chk_tbl_err: assert property (clk_en && tbl_req |=>
        tbl_range_err != tbl_valid) else $error("tbl err");
    chk_unsup_flag: assert property (clk_en &&
        nibble_to_byte_output_instruction |=> unsupported_instr) else $error("u");
    chk_rd_answer: assert property (clk_en && ram_rd |=>
        ram_rd_valid) else $error("rd");
    chk_rd_quiet: assert property (clk_en && !ram_rd |=>
        !ram_rd_valid) else $error("rd quiet");
endmodule // pdmm_map_props
bind pdmm_program_data_memory_map pdmm_map_props
    #(.LARGE_VARIANT(LARGE_VARIANT)) u_pdmm_map_props (.*);
`default_nettype wire

// ==== verification/pdmm_program_data_memory_map_tb.sv ====
// bench: large variant, small variant beside it
`timescale 1ns/1ps
`default_nettype none
module pdmm_program_data_memory_map_tb;
    logic sys_clk = 0;
    int bad_count = 0, tests_run = 0;
    wire srst, clk_en, fetch_req, tbl_req, rom_wr, ram_rd, ram_wr, fetch_valid,
        nibble_to_byte_output_instruction, fetch_range_err, tbl_valid,
        tbl_range_err, ram_rd_valid, unsupported_instr;
    wire [11:0] fetch_addr, table_pointer_register, rom_wr_addr;
    wire [7:0] rom_wr_data, data_pointer_pair, fetch_data, tbl_data;
    wire [3:0] ram_wr_data, ram_rd_data, rds;
    wire fvs, frs;
    always #5 sys_clk = ~sys_clk;
    pdmm_cpu_model u_pdmm_cpu_model (.*);
    pdmm_program_data_memory_map #(.LARGE_VARIANT(1))
        u_pdmm_program_data_memory_map (.*);
    pdmm_program_data_memory_map u_pdmm_program_data_memory_map_s (.*,
        .ram_rd_data(rds), .fetch_data(), .fetch_valid(fvs),
        .fetch_range_err(frs),
        .tbl_data(), .tbl_valid(), .tbl_range_err(), .ram_rd_valid(),
        .unsupported_instr());
    task cmp(input string n, input logic [11:0] e, g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task go(input [5:0] k, input [11:0] a, input [7:0] d);
        u_pdmm_cpu_model.op(k, a, d);
        #1;
    endtask
    task complete_run;
        if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task t_reset_state;
        cmp("rst_fetch", 12'h000, {fetch_valid, fetch_range_err});
        cmp("rst_tbl", 12'h000, {tbl_valid, tbl_range_err});
        cmp("rst_ram", 12'h000, ram_rd_valid);
        cmp("rst_unsup", 12'h000, unsupported_instr);
    endtask
    task t_small_range;
        go(1, 12'h0800, 0);
        cmp("fetch_s", 12'h001, {fvs, frs});
        cmp("fetch_l", 12'h002, {fetch_valid, fetch_range_err});
    endtask
    task t_freeze;
        u_pdmm_cpu_model.hold(0);
        go(1, 12'h07FF, 0);
        cmp("frz_fetch", 12'h000, {fetch_valid, fetch_range_err});
        go(16, 12'h0015, 8'h0C);
        u_pdmm_cpu_model.hold(1);
        go(8, 12'h0095, 0);
        cmp("frz_ram_s", 12'h0003, rds);
        go(1, 12'h07FF, 0);
        cmp("fetch", 12'h025A, {fetch_valid, fetch_range_err, fetch_data});
    endtask
    task t_rom_paths;
        go(4, 12'h0BFF, 8'hA5);
        go(4, 12'h07FF, 8'h5A);
        go(1, 12'h07FF, 0);
        cmp("fetch", 12'h025A, {fetch_valid, fetch_range_err, fetch_data});
        go(2, 12'h0BFF, 0);
        cmp("tbl", 12'h02A5, {tbl_valid, tbl_range_err, tbl_data});
        go(2, 12'h0C00, 0);
        cmp("tbl", 12'h01A5, {tbl_valid, tbl_range_err, tbl_data});
    endtask
    task t_ram_alias;
        go(16, 12'h0085, 8'h09);
        go(8, 12'h00C5, 0);
        cmp("ram", 12'h0019, {ram_rd_valid, ram_rd_data});
        go(8, 12'h0005, 0);
        cmp("ram_s", 12'h0009, rds);
        go(16, 12'h0015, 8'h03);
        go(8, 12'h0095, 0);
        cmp("ram_s", 12'h0003, rds);
    endtask
    task t_unsupported;
        go(32, 12'h0000, 0);
        cmp("unsup", 12'h0001, unsupported_instr);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        u_pdmm_cpu_model.release_reset;
        #1;
        t_reset_state;
        t_rom_paths;
        t_ram_alias;
        t_unsupported;
        t_small_range;
        t_freeze;
        complete_run;
    end
endmodule // pdmm_program_data_memory_map_tb
`default_nettype wire
